//--- common/fbg_pkg.sv
// Constants, types and helpers of the gateway serial-configuration block
// Assumes one 10 MHz clock; all inputs are synchronous to it
//
// Contract
// - Master serial settings must equal the trip unit slave settings to communicate.
// - Polled slave address settable 1 to 247, default 2, used in requests.
// - Line rate selects 9600, 19200, 38400 or 57600 bit/s; 19200 after power-up.
// - Parity coded 00 none, 01 odd, 02 even; even by default.
// - Characters always use exactly one stop bit, not configurable.
// - A valid setting write takes effect at once, no commit needed; the code holds it off the line until FRAME_BUSY is low.
// - A write with an out-of-range value is ignored; setting keeps old value.
// - Settings are not retained; every power-up restores all defaults.
// - The trip unit's own serial settings cannot be changed from here.
// - On the variant without communication, no trip unit object is reachable.
// - Input-status object sits at index 2001 hex, sub index 0, 4 bytes.
// - Low 16 bits are status, high 16 validity; unassigned bits read zero.
// - Status bits 1,2,3,5,6: closed, trip, alarm, maintenance, test.
// - Status bits 9,10,11,13: clockwise phases, overload, zone selectivity, source ground.
// - Each validity bit sixteen above flags that status as supported and valid.
// - Real-time objects readable at sub 0 as float and fixed objects apart.
// - A fixed-point object returns the quantity times its scale factor.
// - Energy quantities exist only as fixed-point objects.
// - Quantities lacking a float index are offered only in fixed point.
package fbg_pkg;

	// ****************************************
	// Object indexes
	// ****************************************
	localparam logic [15:0] IDX_STATUS   = 16'h2001;
	localparam logic [15:0] IDX_SLAVE    = 16'h21F4;
	localparam logic [15:0] IDX_RATE     = 16'h21F5;
	localparam logic [15:0] IDX_PARITY   = 16'h21F6;
	localparam logic [15:0] IDX_FLT_BASE = 16'h2038;
	localparam logic [15:0] IDX_FLT_LAST = 16'h205A;
	localparam logic [15:0] IDX_FIX_BASE = 16'h20B6;
	localparam logic [15:0] IDX_FIX_LAST = 16'h20E0;
	localparam logic [7:0]  SUB_ZERO     = 8'h00;

	// ****************************************
	// Settings and reset values
	// ****************************************
	localparam logic [31:0] ADDR_MIN     = 32'h0000_0001;
	localparam logic [31:0] ADDR_MAX     = 32'h0000_00F7;
	localparam logic [7:0]  ADDR_DEF     = 8'h02;
	localparam logic [7:0]  RATE_9600    = 8'h00;
	localparam logic [7:0]  RATE_19200   = 8'h01;
	localparam logic [7:0]  RATE_38400   = 8'h02;
	localparam logic [7:0]  RATE_57600   = 8'h03;
	localparam logic [7:0]  PAR_NONE     = 8'h00;
	localparam logic [7:0]  PAR_ODD      = 8'h01;
	localparam logic [7:0]  PAR_EVEN     = 8'h02;
	localparam logic [1:0]  STOP_BITS    = 2'h1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_HZ       = 10_000_000;
	localparam logic [11:0] DIV_9600     = 12'(CLK_HZ / 9600);
	localparam logic [11:0] DIV_19200    = 12'(CLK_HZ / 19200);
	localparam logic [11:0] DIV_38400    = 12'(CLK_HZ / 38400);
	localparam logic [11:0] DIV_57600    = 12'(CLK_HZ / 57600);

	// ****************************************
	// Real-time slots
	// ****************************************
	localparam int          SLOT_W       = 6;
	localparam int          SLOT_COUNT   = 43;
	localparam logic [5:0]  SLOT_IL1     = 6'h01;
	localparam logic [5:0]  SLOT_UL3N    = 6'h0B;
	localparam logic [5:0]  SLOT_PF      = 6'h13;
	localparam logic [5:0]  SLOT_FREQ_LO = 6'h14;
	localparam logic [5:0]  SLOT_FREQ_HI = 6'h1B;
	localparam logic [5:0]  SLOT_ENERGY  = 6'h1C;
	localparam logic [5:0]  ENERGY_SKIP  = 6'h08;
	localparam logic [31:0] SCALE_1      = 32'h0000_0001;
	localparam logic [31:0] SCALE_10     = 32'h0000_000A;
	localparam logic [31:0] SCALE_100    = 32'h0000_0064;

	typedef struct packed {
		logic src_ground;
		logic zone_selectivity_active;
		logic overload;
		logic clockwise_phase_order;
		logic test_mode;
		logic maint_mode;
		logic alarm;
		logic trip;
		logic closed;
	} fbg_flags_t;

	typedef struct packed {
		fbg_flags_t valid;
		fbg_flags_t state;
	} fbg_trip_status_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] rate;
		logic [7:0] parity;
	} fbg_rtu_cfg_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} fbg_obj_cmd_t;

	// Places flags at bits 1,2,3,5,6,9,10,11,13 counted from one
	function automatic logic [15:0] spread(input fbg_flags_t f);
		spread = {3'h0, f.src_ground, 1'b0, f.zone_selectivity_active,
			f.overload, f.clockwise_phase_order, 2'h0, f.test_mode,
			f.maint_mode, 1'b0, f.alarm, f.trip, f.closed};
	endfunction : spread

	function automatic logic [31:0] pack_status(input fbg_trip_status_t s);
		pack_status = {spread(s.valid), spread(s.state)};
	endfunction : pack_status

	function automatic logic [31:0] scale_of(input logic [5:0] slot);
		if (slot >= SLOT_IL1 && slot <= SLOT_UL3N) scale_of = SCALE_10;
		else if (slot == SLOT_PF || slot == SLOT_FREQ_HI) scale_of = SCALE_100;
		else if (slot == SLOT_FREQ_LO) scale_of = SCALE_10;
		else scale_of = SCALE_1;
	endfunction : scale_of

	// Float offsets skip the energy slots, which have no float form
	function automatic logic [5:0] flt_to_slot(input logic [5:0] f);
		flt_to_slot = (f < SLOT_ENERGY) ? f : 6'(f + ENERGY_SKIP);
	endfunction : flt_to_slot

	function automatic logic [11:0] rate_div(input logic [7:0] code);
		case (code)
			RATE_9600:  rate_div = DIV_9600;
			RATE_38400: rate_div = DIV_38400;
			RATE_57600: rate_div = DIV_57600;
			default:    rate_div = DIV_19200;
		endcase
	endfunction : rate_div

endpackage : fbg_pkg

//--- dv/fbg_rtu_slave.sv
// Stand-in for the trip unit RTU slave: frame timing and fixed slave settings
// Assumes the gateway's CLK, RTU_CFG and BAUD_TICK; go is a one-cycle bench pulse
`timescale 1ns/10ps
`default_nettype none
module fbg_rtu_slave
	import fbg_pkg::*;
#(
	parameter int FRAME_BITS = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Gateway side
	input  wire fbg_rtu_cfg_t cfg,
	input  wire logic         baud_tick,
	input  wire logic         go,
	output var  logic         frame_busy,
	output var  logic         in_sync
);
	// ****************************************
	// Slave settings and frame counter
	// ****************************************
	// Own settings are fixed; nothing on the gateway reaches them
	localparam fbg_rtu_cfg_t SLAVE_CFG = {ADDR_DEF, RATE_19200, PAR_EVEN};
	int bits;
	assign in_sync    = (cfg === SLAVE_CFG);
	assign frame_busy = (bits > 0);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bits <= 0;
		end else if (go) begin
			bits <= FRAME_BITS;
		end else if (baud_tick && bits > 0) begin
			bits <= bits - 1;
		end
	end
endmodule : fbg_rtu_slave
`default_nettype wire

//--- dv/tb_fbg_gateway_cfg.sv
// Self-checking bench of the gateway object access and serial settings
// Assumes the RTU slave stand-in of dv/fbg_rtu_slave.sv
`timescale 1ns/10ps
`default_nettype none
module tb_fbg_gateway_cfg
	import fbg_pkg::*;
;
	logic              CLK = 1'b0;
	logic              NRST = 1'b0;
	logic              OBJ_REQ = 1'b0;
	fbg_obj_cmd_t      OBJ_CMD = '0;
	logic              OBJ_ACK;
	logic              OBJ_ERR;
	logic [31:0]       OBJ_RDATA;
	logic              COMMLESS_RELEASE_VARIANT = 1'b0;
	fbg_trip_status_t  TRIP_STATUS = '0;
	logic              RT_WR = 1'b0;
	logic [SLOT_W-1:0] RT_SLOT = '0;
	logic [31:0]       RT_RAW = '0;
	logic [31:0]       RT_FLOAT = '0;
	logic              FRAME_BUSY;
	fbg_rtu_cfg_t      RTU_CFG;
	logic [1:0]        RTU_STOP_BITS;
	logic              BAUD_TICK;
	logic              go = 1'b0;
	logic              in_sync;
	fbg_rtu_cfg_t      ec = {ADDR_DEF, RATE_19200, PAR_EVEN};
	int                errors = 0;
	int                n_tests = 0;
	int                gap;
	// Bit position of flag k, closed first
	int                pos [9] = '{0, 1, 2, 4, 5, 8, 9, 10, 12};
	int                bps [4] = '{9600, 19200, 38400, 57600};

	always #50 CLK = ~CLK;

	fbg_gateway_cfg dut_u (.CLK, .NRST, .OBJ_REQ, .OBJ_CMD, .OBJ_ACK, .OBJ_ERR, .OBJ_RDATA,
		.COMMLESS_RELEASE_VARIANT, .TRIP_STATUS, .RT_WR, .RT_SLOT, .RT_RAW, .RT_FLOAT,
		.FRAME_BUSY, .RTU_CFG, .RTU_STOP_BITS, .BAUD_TICK);
	fbg_rtu_slave slave_u (.clk(CLK), .nrst(NRST), .cfg(RTU_CFG), .baud_tick(BAUD_TICK),
		.go(go), .frame_busy(FRAME_BUSY), .in_sync(in_sync));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic results();
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// A bound that runs out counts as a mismatch; the run goes on to results
	task automatic tmo();
		chk(32'h0, 32'h1);
	endtask : tmo

	// One-shot request: high for one edge, then wait for the answer
	task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic e, input logic [31:0] rd);
		int n;
		@(posedge CLK) #1;
		OBJ_REQ = 1'b1;
		OBJ_CMD = {wr, idx, sub, wd};
		@(posedge CLK) #1;
		OBJ_REQ = 1'b0;
		n = 0;
		while (OBJ_ACK !== 1'b1 && n < 4) begin
			@(posedge CLK) #1;
			n++;
		end
		if (OBJ_ACK !== 1'b1) tmo();
		chk({31'h0, OBJ_ERR}, {31'h0, e});
		chk(OBJ_RDATA, rd);
	endtask : obj

	// Setting write, then the line value one edge later
	task automatic setw(input logic [15:0] idx, input logic [31:0] v, input logic e);
		obj(1'b1, idx, SUB_ZERO, v, e, 32'h0);
		if (!e && idx == IDX_SLAVE) ec.addr = v[7:0];
		if (!e && idx == IDX_RATE) ec.rate = v[7:0];
		if (!e && idx == IDX_PARITY) ec.parity = v[7:0];
		@(posedge CLK) #1;
		chk(32'(RTU_CFG), 32'(ec));
		chk(32'(RTU_STOP_BITS), 32'h1);
	endtask : setw

	task automatic tick_gap(output int n);
		n = 0;
		do begin
			@(posedge CLK) #1;
			n++;
		end while (BAUD_TICK !== 1'b1 && n < 3000);
		if (BAUD_TICK !== 1'b1) tmo();
	endtask : tick_gap

	task automatic rt_wr(input logic [5:0] s, input logic [31:0] raw, input logic [31:0] f);
		@(posedge CLK) #1;
		{RT_WR, RT_SLOT, RT_RAW, RT_FLOAT} = {1'b1, s, raw, f};
		@(posedge CLK) #1;
		RT_WR = 1'b0;
	endtask : rt_wr

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge CLK);
		#1 NRST = 1'b1;
		chk(32'(RTU_CFG), 32'h0002_0102);
		chk(32'(in_sync), 32'h1);
		obj(1'b0, IDX_SLAVE, SUB_ZERO, 32'h0, 1'b0, 32'h2);
		tick_gap(gap);
		tick_gap(gap);
		chk(32'(gap), 32'(CLK_HZ / 19200));
		setw(IDX_SLAVE, 32'd247, 1'b0);
		setw(IDX_SLAVE, 32'd1, 1'b0);
		chk(32'(in_sync), 32'h0);
		setw(IDX_SLAVE, 32'd0, 1'b1);
		setw(IDX_SLAVE, 32'd248, 1'b1);
		setw(IDX_SLAVE, 32'h0000_0105, 1'b1);
		obj(1'b0, IDX_SLAVE, SUB_ZERO, 32'h0, 1'b0, 32'h1);
		for (int i = 0; i < 4; i++) begin
			setw(IDX_RATE, i, 1'b0);
			repeat (3) tick_gap(gap);
			chk(32'(gap), 32'(CLK_HZ / bps[i]));
		end
		setw(IDX_RATE, 32'h4, 1'b1);
		for (int i = 0; i < 3; i++) setw(IDX_PARITY, i, 1'b0);
		setw(IDX_PARITY, 32'h3, 1'b1);
		obj(1'b1, 16'h21F7, SUB_ZERO, 32'h2, 1'b1, 32'h0);
		// Change during a frame waits for the frame end
		@(posedge CLK) #1 go = 1'b1;
		@(posedge CLK) #1 go = 1'b0;
		obj(1'b1, IDX_SLAVE, SUB_ZERO, 32'd9, 1'b0, 32'h0);
		@(posedge CLK) #1;
		chk(32'(RTU_CFG), 32'(ec));
		obj(1'b0, IDX_SLAVE, SUB_ZERO, 32'h0, 1'b0, 32'd9);
		for (int n = 0; n < 3000 && FRAME_BUSY !== 1'b0; n++) @(posedge CLK) #1;
		if (FRAME_BUSY !== 1'b0) tmo();
		ec.addr = 8'd9;
		@(posedge CLK) #1;
		chk(32'(RTU_CFG), 32'(ec));
		// Input status
		for (int k = 0; k < 9; k++) begin
			TRIP_STATUS = {9'(1 << (8 - k)), 9'(1 << k)};
			obj(1'b0, IDX_STATUS, SUB_ZERO, 32'h0, 1'b0,
				(32'h1 << (pos[8 - k] + 16)) | (32'h1 << pos[k]));
		end
		TRIP_STATUS = '1;
		obj(1'b0, IDX_STATUS, SUB_ZERO, 32'h0, 1'b0, 32'h1737_1737);
		obj(1'b0, IDX_STATUS, 8'h01, 32'h0, 1'b1, 32'h0);
		obj(1'b1, IDX_STATUS, SUB_ZERO, 32'h0, 1'b1, 32'h0);
		obj(1'b0, 16'h2002, SUB_ZERO, 32'h0, 1'b1, 32'h0);
		// Real-time objects
		rt_wr(6'h01, 32'd123, 32'h42F6_0000);
		rt_wr(6'h13, 32'd87, 32'h3F5E_B852);
		rt_wr(6'h1C, 32'h0000_1234, 32'h1111_1111);
		rt_wr(6'h24, 32'd5, 32'h40A0_0000);
		rt_wr(6'h2A, 32'h0000_0007, 32'h40E0_0000);
		obj(1'b0, 16'h20B7, SUB_ZERO, 32'h0, 1'b0, 32'd1230);
		obj(1'b0, 16'h2039, SUB_ZERO, 32'h0, 1'b0, 32'h42F6_0000);
		obj(1'b0, 16'h20C9, SUB_ZERO, 32'h0, 1'b0, 32'd8700);
		obj(1'b0, 16'h20D2, SUB_ZERO, 32'h0, 1'b0, 32'h0000_1234);
		obj(1'b0, 16'h2054, SUB_ZERO, 32'h0, 1'b0, 32'h40A0_0000);
		obj(1'b0, 16'h20E0, SUB_ZERO, 32'h0, 1'b0, 32'h0000_0007);
		obj(1'b0, 16'h205A, SUB_ZERO, 32'h0, 1'b0, 32'h40E0_0000);
		obj(1'b0, 16'h20B7, 8'h01, 32'h0, 1'b1, 32'h0);
		// Variant without communication
		COMMLESS_RELEASE_VARIANT = 1'b1;
		obj(1'b0, IDX_STATUS, SUB_ZERO, 32'h0, 1'b1, 32'h0);
		obj(1'b0, 16'h20B7, SUB_ZERO, 32'h0, 1'b1, 32'h0);
		obj(1'b0, IDX_PARITY, SUB_ZERO, 32'h0, 1'b0, 32'(ec.parity));
		COMMLESS_RELEASE_VARIANT = 1'b0;
		// Second power-up restores defaults
		@(posedge CLK) #1 NRST = 1'b0;
		repeat (2) @(posedge CLK);
		#1 NRST = 1'b1;
		chk(32'(RTU_CFG), 32'h0002_0102);
		obj(1'b0, IDX_RATE, SUB_ZERO, 32'h0, 1'b0, 32'(RATE_19200));
		results();
	end
endmodule : tb_fbg_gateway_cfg
`default_nettype wire

//--- logic/fbg_gateway_cfg.sv
// Gateway object access: serial master settings, input status, real-time data
// Assumes object requests, trip status and frame state synchronous to CLK
`timescale 1ns/10ps
`default_nettype none
module fbg_gateway_cfg
	import fbg_pkg::*;
#(
	parameter int RT_DEPTH = SLOT_COUNT
) (
	// Clock and reset
	input  wire logic             CLK,
	input  wire logic             NRST,
	// Object access
	input  wire logic             OBJ_REQ,
	input  wire fbg_obj_cmd_t     OBJ_CMD,
	output var  logic             OBJ_ACK,
	output var  logic             OBJ_ERR,
	output var  logic [31:0]      OBJ_RDATA,
	// Trip unit data
	input  wire logic             COMMLESS_RELEASE_VARIANT,
	input  wire fbg_trip_status_t TRIP_STATUS,
	input  wire logic             RT_WR,
	input  wire logic [SLOT_W-1:0] RT_SLOT,
	input  wire logic [31:0]      RT_RAW,
	input  wire logic [31:0]      RT_FLOAT,
	// Serial master side
	input  wire logic             FRAME_BUSY,
	output var  fbg_rtu_cfg_t     RTU_CFG,
	output var  logic [1:0]       RTU_STOP_BITS,
	output var  logic             BAUD_TICK
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_MEM  = 1'b1
	} fbg_state_t;

	localparam fbg_rtu_cfg_t CFG_DEF = '{addr: ADDR_DEF, rate: RATE_19200,
		parity: PAR_EVEN};

	fbg_state_t        state;
	fbg_state_t        next_state;
	fbg_rtu_cfg_t      stage;
	fbg_rtu_cfg_t      next_stage;
	fbg_rtu_cfg_t      next_cfg;
	logic              rd_float;
	logic              next_rd_float;
	logic              next_ack;
	logic              next_err;
	logic [31:0]       next_rdata;
	logic              mem_rd;
	logic [SLOT_W-1:0] mem_addr;
	logic [63:0]       mem_q;
	logic [63:0]       prod;
	logic [11:0]       cnt;
	logic [11:0]       next_cnt;
	logic              next_tick;
	logic              take;
	logic [15:0]       idx;
	logic [31:0]       wdata;

	if (RT_DEPTH < SLOT_COUNT || RT_DEPTH > (1 << SLOT_W)) begin : g_chk
		$error("RT_DEPTH cannot hold the real-time slots");
	end

	assign take  = OBJ_REQ && state == ST_IDLE;
	assign idx   = OBJ_CMD.index;
	assign wdata = OBJ_CMD.wdata;

	function automatic logic wr_ok(input logic [15:0] i, input logic [31:0] v);
		if (i == IDX_SLAVE) wr_ok = v >= ADDR_MIN && v <= ADDR_MAX;
		else if (i == IDX_RATE) wr_ok = v <= 32'(RATE_57600);
		else wr_ok = v <= 32'(PAR_EVEN);
	endfunction : wr_ok

	// ****************************************
	// Real-time store
	// ****************************************
	// Fixed form is scaled on the way in, kept to 32 bits
	assign prod = RT_RAW * scale_of(RT_SLOT);

	fbg_rt_mem #(
		.WIDTH (64),
		.DEPTH (RT_DEPTH),
		.AW    (SLOT_W)
	) u_mem (
		.clk     (CLK),
		.nrst    (NRST),
		.wr_en   (RT_WR),
		.wr_addr (RT_SLOT),
		.wr_data ({RT_FLOAT, prod[31:0]}),
		.rd_en   (mem_rd),
		.rd_addr (mem_addr),
		.rd_data (mem_q)
	);

	// ****************************************
	// Object access and settings
	// ****************************************
	always_comb begin
		next_state    = state;
		next_stage    = stage;
		next_rd_float = rd_float;
		next_ack      = 1'b0;
		next_err      = OBJ_ERR;
		next_rdata    = OBJ_RDATA;
		mem_rd        = 1'b0;
		mem_addr      = '0;
		// Real-time read: memory word arrives one cycle after the take
		if (state == ST_MEM) begin
			next_state = ST_IDLE;
			next_ack   = 1'b1;
			next_err   = 1'b0;
			next_rdata = rd_float ? mem_q[63:32] : mem_q[31:0];
		end else if (take) begin
			next_ack   = 1'b1;
			next_err   = 1'b0;
			next_rdata = '0;
			if (OBJ_CMD.sub != SUB_ZERO) begin
				next_err = 1'b1;
			end else if (idx == IDX_SLAVE || idx == IDX_RATE || idx == IDX_PARITY) begin
				// Only the master-side copies exist; nothing is forwarded
				if (!OBJ_CMD.wr) begin
					next_rdata = (idx == IDX_SLAVE) ? {24'h0, stage.addr} :
						(idx == IDX_RATE) ? {24'h0, stage.rate} :
						{24'h0, stage.parity};
				end else if (!wr_ok(idx, wdata)) begin
					next_err = 1'b1;
				end else if (idx == IDX_SLAVE) begin
					next_stage.addr = wdata[7:0];
				end else if (idx == IDX_RATE) begin
					next_stage.rate = wdata[7:0];
				end else begin
					next_stage.parity = wdata[7:0];
				end
			end else if (COMMLESS_RELEASE_VARIANT || OBJ_CMD.wr) begin
				next_err = 1'b1;
			end else if (idx == IDX_STATUS) begin
				next_rdata = pack_status(TRIP_STATUS);
			end else if (idx >= IDX_FIX_BASE && idx <= IDX_FIX_LAST) begin
				next_ack      = 1'b0;
				next_state    = ST_MEM;
				next_rd_float = 1'b0;
				mem_rd        = 1'b1;
				mem_addr      = SLOT_W'(idx - IDX_FIX_BASE);
			end else if (idx >= IDX_FLT_BASE && idx <= IDX_FLT_LAST) begin
				next_ack      = 1'b0;
				next_state    = ST_MEM;
				next_rd_float = 1'b1;
				mem_rd        = 1'b1;
				mem_addr      = flt_to_slot(SLOT_W'(idx - IDX_FLT_BASE));
			end else begin
				next_err = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state     <= ST_IDLE;
			stage     <= CFG_DEF;
			rd_float  <= 1'b0;
			OBJ_ACK   <= 1'b0;
			OBJ_ERR   <= 1'b0;
			OBJ_RDATA <= '0;
		end else begin
			state     <= next_state;
			stage     <= next_stage;
			rd_float  <= next_rd_float;
			OBJ_ACK   <= next_ack;
			OBJ_ERR   <= next_err;
			OBJ_RDATA <= next_rdata;
		end
	end

	// ****************************************
	// Applied settings and bit-rate divider
	// ****************************************
	always_comb begin
		next_cfg  = FRAME_BUSY ? RTU_CFG : stage;
		// Reload reads the applied rate, so a new rate starts at the next bit
		next_tick = cnt == 12'h000;
		next_cnt  = next_tick ? 12'(rate_div(RTU_CFG.rate) - 12'h001) :
			12'(cnt - 12'h001);
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RTU_CFG       <= CFG_DEF;
			RTU_STOP_BITS <= STOP_BITS;
			cnt           <= '0;
			BAUD_TICK     <= 1'b0;
		end else begin
			RTU_CFG       <= next_cfg;
			RTU_STOP_BITS <= STOP_BITS;
			cnt           <= next_cnt;
			BAUD_TICK     <= next_tick;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking dcb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_addr_range: assert property (
		RTU_CFG.addr >= ADDR_MIN[7:0] && RTU_CFG.addr <= ADDR_MAX[7:0])
		else $error("Applied slave address out of range");
	a_stop_one: assert property (RTU_STOP_BITS == STOP_BITS)
		else $error("Stop bit count not one");
	a_good_addr: assert property (
		take && OBJ_CMD.wr && idx == IDX_SLAVE && OBJ_CMD.sub == SUB_ZERO
		&& wr_ok(idx, wdata) |=> stage.addr == $past(wdata[7:0]) && !OBJ_ERR)
		else $error("Valid address write not taken");
	a_bad_kept: assert property (
		take && OBJ_CMD.wr && idx == IDX_PARITY && wdata > 32'(PAR_EVEN)
		|=> $stable(stage) && OBJ_ACK && OBJ_ERR)
		else $error("Invalid parity write changed a setting");
	a_frame_hold: assert property (FRAME_BUSY |=> $stable(RTU_CFG))
		else $error("Settings changed inside a frame");
	a_idle_apply: assert property (!FRAME_BUSY |=> RTU_CFG == $past(stage))
		else $error("Settings not applied between frames");
	a_commless_off: assert property (
		take && COMMLESS_RELEASE_VARIANT && idx == IDX_STATUS |=> OBJ_ACK && OBJ_ERR)
		else $error("Trip data reachable on variant without communication");
	a_status_word: assert property (
		take && !OBJ_CMD.wr && !COMMLESS_RELEASE_VARIANT && idx == IDX_STATUS
		&& OBJ_CMD.sub == SUB_ZERO |=> OBJ_ACK && !OBJ_ERR
		&& OBJ_RDATA == pack_status($past(TRIP_STATUS)))
		else $error("Input status word mismatch");
	a_rt_latency: assert property (
		take && !OBJ_CMD.wr && !COMMLESS_RELEASE_VARIANT && OBJ_CMD.sub == SUB_ZERO
		&& idx >= IDX_FIX_BASE && idx <= IDX_FIX_LAST |=> !OBJ_ACK ##1 OBJ_ACK)
		else $error("Real-time read answer not two cycles after request");

	// ****************************************
	// Setting range and write checks
	// ****************************************
	a_stage_addr: assert property (
		stage.addr >= ADDR_MIN[7:0] && stage.addr <= ADDR_MAX[7:0])
		else $error("Staged slave address out of range");
	a_rate_range: assert property (RTU_CFG.rate <= RATE_57600)
		else $error("Applied line rate code out of range");
	a_parity_range: assert property (RTU_CFG.parity <= PAR_EVEN)
		else $error("Applied parity code out of range");
	a_rate_write: assert property (
		take && OBJ_CMD.wr && idx == IDX_RATE && OBJ_CMD.sub == SUB_ZERO
		&& wdata <= 32'(RATE_57600)
		|=> stage.rate == $past(wdata[7:0]) && OBJ_ACK && !OBJ_ERR)
		else $error("Valid rate write not taken");
	a_parity_write: assert property (
		take && OBJ_CMD.wr && idx == IDX_PARITY && OBJ_CMD.sub == SUB_ZERO
		&& wdata <= 32'(PAR_EVEN)
		|=> stage.parity == $past(wdata[7:0]) && OBJ_ACK && !OBJ_ERR)
		else $error("Valid parity write not taken");
	a_bad_addr: assert property (
		take && OBJ_CMD.wr && idx == IDX_SLAVE
		&& (wdata < ADDR_MIN || wdata > ADDR_MAX)
		|=> $stable(stage) && OBJ_ACK && OBJ_ERR)
		else $error("Invalid address write changed a setting");
	a_bad_rate: assert property (
		take && OBJ_CMD.wr && idx == IDX_RATE && wdata > 32'(RATE_57600)
		|=> $stable(stage) && OBJ_ACK && OBJ_ERR)
		else $error("Invalid rate write changed a setting");
	a_err_nodata: assert property (
		OBJ_ACK && OBJ_ERR |-> OBJ_RDATA == 32'h0000_0000)
		else $error("Refused request returned data");

	// ****************************************
	// Object map and bit tick checks
	// ****************************************
	a_sub_refused: assert property (
		take && OBJ_CMD.sub != SUB_ZERO |=> $stable(stage) && OBJ_ACK && OBJ_ERR)
		else $error("Non-zero sub index accepted");
	a_status_ro: assert property (
		take && OBJ_CMD.wr && idx == IDX_STATUS |=> OBJ_ACK && OBJ_ERR)
		else $error("Write to input status accepted");
	a_only_master: assert property (
		take && OBJ_CMD.wr && idx != IDX_SLAVE && idx != IDX_RATE && idx != IDX_PARITY
		|=> $stable(stage) && OBJ_ACK && OBJ_ERR)
		else $error("Write outside master settings accepted");
	a_commless_rt: assert property (
		take && COMMLESS_RELEASE_VARIANT && idx >= IDX_FLT_BASE && idx <= IDX_FIX_LAST
		|=> OBJ_ACK && OBJ_ERR)
		else $error("Real-time data reachable on variant without communication");
	a_flt_latency: assert property (
		take && !OBJ_CMD.wr && !COMMLESS_RELEASE_VARIANT && OBJ_CMD.sub == SUB_ZERO
		&& idx >= IDX_FLT_BASE && idx <= IDX_FLT_LAST
		|=> !OBJ_ACK ##1 OBJ_ACK && !OBJ_ERR)
		else $error("Float read answer not two cycles after request");
	a_tick_gap: assert property (BAUD_TICK |=> !BAUD_TICK [*8])
		else $error("Bit tick repeated too soon");

	// Main scenarios
	c_status_read: cover property (take && idx == IDX_STATUS ##1 OBJ_ACK && !OBJ_ERR);
	c_rt_float: cover property (take && idx == IDX_FLT_LAST ##2 OBJ_ACK && !OBJ_ERR);
	c_rate_write: cover property (take && OBJ_CMD.wr && idx == IDX_RATE ##1 !OBJ_ERR);
	c_deferred: cover property (FRAME_BUSY && stage != RTU_CFG ##1 !FRAME_BUSY);
	c_commless_err: cover property (take && COMMLESS_RELEASE_VARIANT ##1 OBJ_ERR);

endmodule : fbg_gateway_cfg
`default_nettype wire

//--- logic/fbg_rt_mem.sv
// Real-time value store, one word per slot
// Assumes single clock; read data is registered, one cycle latency
`timescale 1ns/10ps
`default_nettype none
module fbg_rt_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 43,
	parameter int AW    = 6
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read side
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output var  logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("Depth exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (wr_en && int'(wr_addr) < DEPTH) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
		end
	end
endmodule : fbg_rt_mem
`default_nettype wire
